/* File: rtl/acsc_pkg.sv */
package acsc_pkg;

    // ************************************************************
    // shared sizes and reset values
    // ************************************************************
    localparam int NUM_CH = 6;
    localparam int PHASE_W = 8;
    localparam int DATA_W = 24;
    localparam int DIV_W = 8;
    localparam logic [NUM_CH-1:0] SHUT_ALL = 6'h3F;
    localparam logic [NUM_CH-1:0] SHUT_NONE = 6'h00;
    localparam logic [DIV_W-1:0] DRDY_PERIOD = 8'h3F;
    localparam logic [DIV_W-1:0] DIV_ZERO = 8'h00;

    // power control bits as written by the serial port
    typedef struct packed {
        logic [NUM_CH-1:0] shutdown;
        logic external_reference_select;
        logic external_clock_select;
    } acsc_ctrl_t;

    // power enables delivered to the analog and clock trees
    typedef struct packed {
        logic core_clock_en;
        logic input_clock_en;
        logic por_monitor_en;
        logic internal_ref_en;
        logic [NUM_CH-1:0] channel_en;
    } acsc_power_t;

    typedef enum logic [1:0] {ACSC_RUN, ACSC_ALL_OFF, ACSC_FULL_OFF} acsc_mode_t;

endpackage

/* File: rtl/acsc_channel.sv */
`timescale 1ns/1ps
// one channel: phase-aligned data-ready and gated output data
module acsc_channel (
    input wire logic clk, // master clock
    input wire logic reset, // synchronous reset, high
    input wire logic enable, // channel out of shutdown
    input wire logic [acsc_pkg::DIV_W-1:0] base_count, // shared running frame counter
    input wire logic [acsc_pkg::PHASE_W-1:0] phase, // phase delay setting
    input wire logic [acsc_pkg::DATA_W-1:0] sample, // raw converter result
    output logic drdy, // data-ready pulse
    output logic [acsc_pkg::DATA_W-1:0] data // output data word
);

    // ready pulse fires when the shared counter meets this channel's offset
    always_ff @(posedge clk)
    begin
        if (reset)
            drdy <= 1'b0;
        else
            drdy <= enable && (base_count == phase[acsc_pkg::DIV_W-1:0]); // [RL2] [RL4] [RL16]
    end

    // data flushed to zero while shut down
    always_ff @(posedge clk)
    begin
        if (reset)
            data <= 24'h00_0000;
        else if (!enable)
            data <= 24'h00_0000; // [RL15]
        else
            data <= sample;
    end

endmodule

/* File: rtl/acsc_top.sv */
`timescale 1ns/1ps
// Functional notes
// RL1: phase offset kept across shutdown
// RL2: waking channel aligns to active channel
// RL3: single shutdown keeps shared clock running
// RL4: waking channel resyncs with no host action
// RL5: all shut: gate input and core clock
// RL6: any channel wakes: clocks restored
// RL7: full shutdown on all bits set
// RL8: full shutdown: monitors off, no clocks
// RL9: full shutdown: channels and reference off
// RL10: full shutdown keeps register values
// RL11: serial port stays alive in shutdown
// RL12: any bit cleared re-enables supply monitors
// RL13: host may idle clocks in shutdown
// RL14: cleared bit enables channel bias, clock
// RL15: shut channel data reads zero
// RL16: shut channel gives no data-ready
// RL17: full shutdown decoded from live bits
module acsc_top (
    input wire logic CLK, // master clock
    input wire logic RESET, // synchronous reset, high
    input wire logic WR_STROBE, // serial port write pulse, same domain
    input wire acsc_pkg::acsc_ctrl_t WR_CTRL, // power bits written
    input wire logic [acsc_pkg::NUM_CH*acsc_pkg::PHASE_W-1:0] WR_PHASE, // phase settings
    input wire logic [acsc_pkg::NUM_CH*acsc_pkg::DATA_W-1:0] SAMPLES, // converter results
    output acsc_pkg::acsc_ctrl_t CTRL, // register readback
    output acsc_pkg::acsc_power_t POWER, // power and clock enables
    output logic FULL_SHUTDOWN, // full shutdown state
    output logic SPI_ALIVE, // serial port enable
    output logic [acsc_pkg::NUM_CH-1:0] DRDY, // data-ready pulses
    output logic [acsc_pkg::NUM_CH*acsc_pkg::DATA_W-1:0] DATA // output data words
);

    // ************************************************************
    // configuration registers
    // ************************************************************
    logic [acsc_pkg::NUM_CH*acsc_pkg::PHASE_W-1:0] phase;
    logic [acsc_pkg::DIV_W-1:0] base_count;
    logic all_off;
    logic full_off;
    logic reset_tail;
    acsc_pkg::acsc_mode_t next_mode;

    // control bits change only on a write or reset; shutdown never alters them
    always_ff @(posedge CLK)
    begin
        if (RESET)
        begin
            CTRL <= '0;
        end
        else if (WR_STROBE)
        begin
            CTRL <= WR_CTRL; // [RL10] [RL11]
        end
    end

    // phase offsets held through any shutdown
    always_ff @(posedge CLK)
    begin
        if (RESET)
            phase <= '0;
        else if (WR_STROBE)
            phase <= WR_PHASE; // [RL1]
    end

    // ************************************************************
    // power mode decode
    // ************************************************************
    // decode from live register bits
    always_comb
    begin
        all_off = (CTRL.shutdown == acsc_pkg::SHUT_ALL); // [RL5]
        full_off = all_off && CTRL.external_reference_select
            && CTRL.external_clock_select; // [RL7] [RL17]
        if (full_off)
            next_mode = acsc_pkg::ACSC_FULL_OFF;
        else if (all_off)
            next_mode = acsc_pkg::ACSC_ALL_OFF;
        else
            next_mode = acsc_pkg::ACSC_RUN; // [RL6] [RL12]
    end

    // registered enables follow the decoded mode
    always_ff @(posedge CLK)
    begin
        if (RESET)
        begin
            POWER <= '0;
            FULL_SHUTDOWN <= 1'b0;
            SPI_ALIVE <= 1'b0;
        end
        else
        begin
            case (next_mode)
                acsc_pkg::ACSC_FULL_OFF:
                begin
                    POWER.core_clock_en <= 1'b0; // [RL8]
                    POWER.input_clock_en <= 1'b0; // [RL8]
                    POWER.por_monitor_en <= 1'b0; // [RL8]
                    POWER.internal_ref_en <= 1'b0; // [RL9]
                end
                acsc_pkg::ACSC_ALL_OFF:
                begin
                    POWER.core_clock_en <= 1'b0; // [RL5]
                    POWER.input_clock_en <= 1'b0; // [RL5]
                    POWER.por_monitor_en <= 1'b1;
                    POWER.internal_ref_en <= !CTRL.external_reference_select;
                end
                default:
                begin
                    POWER.core_clock_en <= 1'b1; // [RL3] [RL6]
                    POWER.input_clock_en <= 1'b1; // [RL6]
                    POWER.por_monitor_en <= 1'b1; // [RL12]
                    POWER.internal_ref_en <= !CTRL.external_reference_select;
                end
            endcase
            POWER.channel_en <= ~CTRL.shutdown; // [RL14] [RL9]
            FULL_SHUTDOWN <= full_off;
            SPI_ALIVE <= 1'b1; // [RL11]
        end
    end

    // ************************************************************
    // shared frame counter and channels
    // ************************************************************
    // keeps running while any channel is awake; held at zero when all off
    always_ff @(posedge CLK)
    begin
        if (RESET)
            base_count <= acsc_pkg::DIV_ZERO;
        else if (all_off)
            base_count <= acsc_pkg::DIV_ZERO; // [RL5]
        else if (base_count == acsc_pkg::DRDY_PERIOD)
            base_count <= acsc_pkg::DIV_ZERO;
        else
            base_count <= base_count + 8'h01; // [RL3]
    end

    genvar g;
    generate
        for (g = 0; g < acsc_pkg::NUM_CH; g++)
        begin : g_ch
            acsc_channel u_ch (
                .clk(CLK),
                .reset(RESET),
                .enable(!CTRL.shutdown[g]),
                .base_count(base_count),
                .phase(phase[g*acsc_pkg::PHASE_W +: acsc_pkg::PHASE_W]),
                .sample(SAMPLES[g*acsc_pkg::DATA_W +: acsc_pkg::DATA_W]),
                .drdy(DRDY[g]),
                .data(DATA[g*acsc_pkg::DATA_W +: acsc_pkg::DATA_W])
            );
        end
    endgenerate

    // ************************************************************
    // checks
    // ************************************************************
    // checks stay off one more edge: outputs still hold reset values then
    always_ff @(posedge CLK)
    begin
        reset_tail <= RESET;
    end

    sequence s_all_set;
        (CTRL.shutdown == acsc_pkg::SHUT_ALL) && CTRL.external_reference_select
            && CTRL.external_clock_select;
    endsequence

    a_full_gates_all: assert property (@(posedge CLK) disable iff (RESET || reset_tail) // [RL8]
        s_all_set |=> !POWER.core_clock_en && !POWER.input_clock_en && !POWER.por_monitor_en)
        else $error("full shutdown left a clock or monitor on");

    a_full_ref_off: assert property (@(posedge CLK) disable iff (RESET || reset_tail) // [RL9]
        s_all_set |=> !POWER.internal_ref_en && POWER.channel_en == acsc_pkg::SHUT_NONE)
        else $error("full shutdown left reference or channel on");

    a_full_flag: assert property (@(posedge CLK) disable iff (RESET || reset_tail) // [RL7]
        s_all_set |=> FULL_SHUTDOWN)
        else $error("full shutdown not flagged");

    a_monitor_back: assert property (@(posedge CLK) disable iff (RESET || reset_tail) // [RL12]
        !(CTRL.shutdown == acsc_pkg::SHUT_ALL && CTRL.external_reference_select
            && CTRL.external_clock_select) |=> POWER.por_monitor_en && !FULL_SHUTDOWN)
        else $error("monitors not restored");

    a_clock_restore: assert property (@(posedge CLK) disable iff (RESET || reset_tail) // [RL6]
        (CTRL.shutdown != acsc_pkg::SHUT_ALL) |=> POWER.core_clock_en && POWER.input_clock_en)
        else $error("clock not restored");

    a_all_off_gate: assert property (@(posedge CLK) disable iff (RESET || reset_tail) // [RL5]
        (CTRL.shutdown == acsc_pkg::SHUT_ALL) |=> !POWER.core_clock_en)
        else $error("core clock not gated");

    a_regs_kept: assert property (@(posedge CLK) disable iff (RESET || reset_tail) // [RL10]
        !WR_STROBE |=> $stable(CTRL) && $stable(phase))
        else $error("register changed without write");

    a_no_drdy_shut: assert property (@(posedge CLK) disable iff (RESET || reset_tail) // [RL16]
        CTRL.shutdown[0] |=> !DRDY[0])
        else $error("shut channel gave data ready");

    a_zero_data: assert property (@(posedge CLK) disable iff (RESET || reset_tail) // [RL15]
        CTRL.shutdown[0] |=> DATA[acsc_pkg::DATA_W-1:0] == 24'h00_0000)
        else $error("shut channel data not zero");

    a_count_runs: assert property (@(posedge CLK) disable iff (RESET || reset_tail) // [RL3]
        (CTRL.shutdown != acsc_pkg::SHUT_ALL) && base_count != acsc_pkg::DRDY_PERIOD
            |=> base_count == $past(base_count) + 8'h01)
        else $error("shared counter stalled");

    a_channel_enable: assert property (@(posedge CLK) disable iff (RESET || reset_tail) // [RL14]
        1'b1 |=> POWER.channel_en == ~$past(CTRL.shutdown))
        else $error("channel enables do not follow shutdown bits");

    a_spi_alive: assert property (@(posedge CLK) disable iff (RESET || reset_tail) // [RL11]
        1'b1 |=> SPI_ALIVE)
        else $error("serial port not kept alive");

    // every channel: silent and zeroed while shut, aligned while awake
    genvar c;
    generate
        for (c = 0; c < acsc_pkg::NUM_CH; c++)
        begin : g_chk
            a_shut_silent: assert property ( // [RL15] [RL16]
                @(posedge CLK) disable iff (RESET || reset_tail)
                CTRL.shutdown[c] |=> !DRDY[c]
                    && DATA[c*acsc_pkg::DATA_W +: acsc_pkg::DATA_W] == '0)
                else $error("shut channel gave ready or data");

            a_drdy_aligned: assert property ( // [RL2] [RL4]
                @(posedge CLK) disable iff (RESET || reset_tail)
                !CTRL.shutdown[c]
                    && base_count == phase[c*acsc_pkg::PHASE_W +: acsc_pkg::PHASE_W]
                    |=> DRDY[c])
                else $error("awake channel missed its aligned ready");
        end
    endgenerate

endmodule

/* File: bench/acsc_host.sv */
`timescale 1ns/1ps
// host side: writes the power bits over the serial port
module acsc_host (
    input wire logic clk, // master clock
    output logic wr_strobe, // write pulse
    output acsc_pkg::acsc_ctrl_t wr_ctrl, // power bits
    output logic [47:0] wr_phase // phase settings
);
    // start idle; no strobe edges unless a write is asked for
    initial
    begin
        wr_strobe = 1'b0;
        wr_ctrl = 8'h00;
        wr_phase = 48'h0000_0000_0000;
    end
    // one write held for one edge, then buses scrambled so stale data cannot pass
    task automatic write(input logic [7:0] ctrl, input logic [47:0] phase);
    begin
        @(posedge clk);
        wr_strobe <= 1'b1;
        wr_ctrl <= ctrl;
        wr_phase <= phase;
        @(posedge clk);
        wr_strobe <= 1'b0;
        wr_ctrl <= ~ctrl;
        wr_phase <= ~phase;
    end
    endtask
endmodule

/* File: bench/adc_channel_shutdown_control_tb_top.sv */
`timescale 1ns/1ps
// ************************************************************
// power control bench
// ************************************************************
module adc_channel_shutdown_control_tb_top;
    typedef struct packed {logic [7:0] ctrl; logic [9:0] pw; logic full;} acsc_row_t;
    localparam logic [47:0] PH = 48'h0000_0009_0005;
    logic CLK = 1'b0;
    logic RESET = 1'b1;
    logic WR_STROBE;
    acsc_pkg::acsc_ctrl_t WR_CTRL;
    acsc_pkg::acsc_ctrl_t CTRL;
    logic [47:0] WR_PHASE;
    logic [143:0] SAMPLES = {6{24'hA5_5A5A}};
    acsc_pkg::acsc_power_t POWER;
    logic FULL_SHUTDOWN;
    logic SPI_ALIVE;
    logic [5:0] DRDY;
    logic [143:0] DATA;
    int failures = 0;
    int samples_checked = 0;
    int cyc = 0;
    int t0 = 0;
    int t2 = 0;
    int n1 = 0;
    int n1_base = 0;
    acsc_row_t rows [8] = '{'{8'h00, 10'h3FF, 1'b0}, '{8'h02, 10'h3BF, 1'b0},
        '{8'h04, 10'h3FE, 1'b0}, '{8'hFC, 10'h0C0, 1'b0}, '{8'hFF, 10'h000, 1'b1},
        '{8'hFE, 10'h080, 1'b0}, '{8'hFD, 10'h0C0, 1'b0}, '{8'h7F, 10'h3A0, 1'b0}};

    acsc_host u_host (.clk(CLK), .wr_strobe(WR_STROBE), .wr_ctrl(WR_CTRL), .wr_phase(WR_PHASE));
    acsc_top u_dut (.CLK(CLK), .RESET(RESET), .WR_STROBE(WR_STROBE), .WR_CTRL(WR_CTRL),
        .WR_PHASE(WR_PHASE), .SAMPLES(SAMPLES), .CTRL(CTRL), .POWER(POWER),
        .FULL_SHUTDOWN(FULL_SHUTDOWN), .SPI_ALIVE(SPI_ALIVE), .DRDY(DRDY), .DATA(DATA));

    // clock
    always #20 CLK = ~CLK;

    // cycle count, data-ready timestamps and hang guard
    always @(posedge CLK)
    begin
        cyc <= cyc + 1;
        if (DRDY[0]) t0 <= cyc;
        if (DRDY[2]) t2 <= cyc;
        if (DRDY[1]) n1 <= n1 + 1;
        if (cyc == 3000)
        begin
            failures++;
            summarize();
        end
    end

    // compare one value and report a mismatch
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    begin
        samples_checked++;
        if (exp !== got)
        begin
            failures++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    end
    endtask

    // print counts and verdict, then stop
    task automatic summarize();
    begin
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    end
    endtask

    // main sequence: table of writes, then alignment, shutdown output and reset cases
    initial
    begin
        repeat (10) @(posedge CLK);
        check("reset power", 32'h0, 32'(POWER));
        RESET <= 1'b0;
        repeat (3) @(posedge CLK);
        check("power up", 32'h3FF, 32'(POWER));
        foreach (rows[i])
        begin
            u_host.write(rows[i].ctrl, PH);
            repeat (4) @(posedge CLK);
            check("ctrl", 32'(rows[i].ctrl), 32'(CTRL));
            check("power", 32'(rows[i].pw), 32'(POWER));
            check("full", 32'(rows[i].full), 32'(FULL_SHUTDOWN));
            check("spi alive", 32'h1, 32'(SPI_ALIVE));
        end
        u_host.write(8'h08, PH);
        repeat (2) @(posedge CLK);
        n1_base = n1;
        repeat (128) @(posedge CLK);
        check("drdy shut", 32'h0, n1 - n1_base);
        check("data shut", 32'h0, 32'(DATA[47:24]));
        check("data live", 32'hA5_5A5A, 32'(DATA[23:0]));
        check("align", 32'h4, (t2 - t0 + 64) % 64);
        check("clock runs", 32'h1, 32'(cyc - t0 <= 64));
        u_host.write(8'h18, PH);
        u_host.write(8'h08, PH);
        repeat (130) @(posedge CLK);
        check("realign", 32'h4, (t2 - t0 + 64) % 64);
        RESET <= 1'b1;
        repeat (2) @(posedge CLK);
        RESET <= 1'b0;
        repeat (3) @(posedge CLK);
        check("ctrl again", 32'h0, 32'(CTRL));
        check("power again", 32'h3FF, 32'(POWER));
        summarize();
    end
endmodule
